// ===== rtl/pcfg_config_header.sv
`timescale 1ns/10ps
`default_nettype none
module pcfg_config_header #(
    parameter logic [15:0] PART_CODE = 16'h1234, // arbitrary value
    parameter logic [15:0] MAKER_CODE = 16'habcd, // arbitrary value
    parameter logic [7:0] REVISION_CODE = 8'h01 // arbitrary value
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfgValid,
    input wire logic cfgIdsel,
    input wire logic [10:0] cfgAddr,
    input wire logic cfgWrite,
    input wire logic [3:0] cfgByteEnN,
    input wire logic [31:0] cfgWrData,
    output logic cfgAck,
    output logic [31:0] cfgRdData,
    input wire logic subsystemVendorWriteEnable,
    input wire logic parityErrSeen,
    input wire logic addrParityErrTarget,
    input wire logic serrRequest,
    input wire logic masterAbortSeen,
    input wire logic targetAbortReceived,
    input wire logic masterPerrRead,
    input wire logic masterPerrWriteSeen,
    output logic serrOut,
    output logic serrOutEnN,
    output logic targetAbortReq,
    output logic parityReportEn,
    output logic busMasterEn,
    input wire logic masterStartReq,
    output logic masterStart,
    input wire logic masterActive,
    input wire logic grantActive,
    output logic masterStop,
    input wire logic memValid,
    input wire logic [31:0] memAddr,
    output logic memHit
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    logic [15:0] command_ff;
    logic [pcfg_pkg::STS_NUM-1:0] sticky_ff;
    logic [7:0] latency_ff;
    logic [19:0] memBase_ff;
    logic [15:0] subsysId_ff;
    logic [15:0] subsysVendor_ff;
    logic [7:0] latCount_ff;
    logic cfgAck_ff;
    logic [31:0] cfgRdData_ff;
    logic serrDrive_ff;
    logic targetAbort_ff;
    logic accept;
    logic wrAcc;
    logic [7:0] byteOfs;
    logic [3:0] laneOn;
    logic [pcfg_pkg::STS_NUM-1:0] stsEvent;
    logic [31:0] nxt_cfgRdData;
    logic [31:0] statusWord;
    logic [15:0] commandRead;
    logic latExpired;

    // --------------------------------------------------------------
    // configuration decode
    // --------------------------------------------------------------
    // select high, type 0, function zero
    assign accept = cfgValid && cfgIdsel && (cfgAddr[1:0] == pcfg_pkg::CFG_TYPE0)
        && (cfgAddr[10:8] == pcfg_pkg::FUNC_ZERO);
    assign byteOfs = {cfgAddr[7:2], 2'h0};
    assign laneOn = ~cfgByteEnN;
    assign wrAcc = accept && cfgWrite;

    // --------------------------------------------------------------
    // command register
    // --------------------------------------------------------------
    // only bits 8, 6, 2, 1 are kept
    always_ff @(posedge clk) begin
        if (rst) begin
            command_ff <= pcfg_pkg::CMD_RESET;
        end else if (wrAcc && byteOfs == pcfg_pkg::OFS_CMDSTS) begin
            if (laneOn[0]) begin
                command_ff[pcfg_pkg::CMD_MEM] <= cfgWrData[pcfg_pkg::CMD_MEM];
                command_ff[pcfg_pkg::CMD_MASTER] <= cfgWrData[pcfg_pkg::CMD_MASTER];
                command_ff[pcfg_pkg::CMD_PARITY] <= cfgWrData[pcfg_pkg::CMD_PARITY];
            end
            if (laneOn[1]) begin
                command_ff[pcfg_pkg::CMD_SERR] <= cfgWrData[pcfg_pkg::CMD_SERR];
            end
        end
    end

    // unimplemented command bits read zero
    always_comb begin
        commandRead = 16'h0000;
        commandRead[pcfg_pkg::CMD_MEM] = command_ff[pcfg_pkg::CMD_MEM];
        commandRead[pcfg_pkg::CMD_MASTER] = command_ff[pcfg_pkg::CMD_MASTER];
        commandRead[pcfg_pkg::CMD_PARITY] = command_ff[pcfg_pkg::CMD_PARITY];
        commandRead[pcfg_pkg::CMD_SERR] = command_ff[pcfg_pkg::CMD_SERR];
    end

    assign parityReportEn = command_ff[pcfg_pkg::CMD_PARITY];
    assign busMasterEn = command_ff[pcfg_pkg::CMD_MASTER];

    // --------------------------------------------------------------
    // status events and sticky bits
    // --------------------------------------------------------------
    // event sources in sticky order
    assign stsEvent[0] = parityErrSeen || addrParityErrTarget;
    assign stsEvent[1] = serrDrive_ff;
    assign stsEvent[2] = masterAbortSeen;
    assign stsEvent[3] = targetAbortReceived;
    assign stsEvent[4] = targetAbort_ff;
    assign stsEvent[5] = command_ff[pcfg_pkg::CMD_PARITY] && (masterPerrRead || masterPerrWriteSeen);

    // set wins over a write-one clear
    generate
        for (genvar i = 0; i < pcfg_pkg::STS_NUM; i++) begin : g_sticky
            always_ff @(posedge clk) begin
                if (rst) begin
                    sticky_ff[i] <= 1'b0;
                end else if (stsEvent[i]) begin
                    sticky_ff[i] <= 1'b1;
                end else if (wrAcc && byteOfs == pcfg_pkg::OFS_CMDSTS && laneOn[3]
                    && cfgWrData[pcfg_pkg::STS_POS[i]]) begin
                    sticky_ff[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // command and status word as read
    always_comb begin
        statusWord = 32'h00000000;
        for (int k = 0; k < pcfg_pkg::STS_NUM; k++) begin
            statusWord[pcfg_pkg::STS_POS[k]] = sticky_ff[k];
        end
        statusWord[26:25] = pcfg_pkg::STS_DEVSEL_MEDIUM;
        statusWord[pcfg_pkg::STS_FB2B] = 1'b1;
        statusWord[pcfg_pkg::STS_CAPLIST] = 1'b1;
        statusWord[15:0] = commandRead;
    end

    // --------------------------------------------------------------
    // system error and target abort drivers
    // --------------------------------------------------------------
    // open-drain low drive, enable low while driving
    always_ff @(posedge clk) begin
        if (rst) begin
            serrDrive_ff <= 1'b0;
        end else begin
            serrDrive_ff <= serrRequest && command_ff[pcfg_pkg::CMD_SERR];
        end
    end
    assign serrOut = 1'b0;
    assign serrOutEnN = ~serrDrive_ff;

    // target abort on address parity error
    always_ff @(posedge clk) begin
        if (rst) begin
            targetAbort_ff <= 1'b0;
        end else begin
            targetAbort_ff <= addrParityErrTarget;
        end
    end
    assign targetAbortReq = targetAbort_ff;

    // --------------------------------------------------------------
    // latency timer and master gating
    // --------------------------------------------------------------
    // writable latency byte
    always_ff @(posedge clk) begin
        if (rst) begin
            latency_ff <= pcfg_pkg::LAT_RESET;
        end else if (wrAcc && byteOfs == pcfg_pkg::OFS_HDRLAT && laneOn[1]) begin
            latency_ff <= cfgWrData[15:8];
        end
    end

    // load on start, count down while master owns the bus
    always_ff @(posedge clk) begin
        if (rst) begin
            latCount_ff <= 8'h00;
        end else if (masterStart) begin
            latCount_ff <= latency_ff;
        end else if (masterActive && latCount_ff != 8'h00) begin
            latCount_ff <= latCount_ff - 8'h01;
        end
    end
    assign latExpired = latCount_ff == 8'h00;
    assign masterStart = masterStartReq && command_ff[pcfg_pkg::CMD_MASTER];
    assign masterStop = masterActive && latExpired && !grantActive;

    // --------------------------------------------------------------
    // memory window base and decode
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            memBase_ff <= 20'h00000;
        end else if (wrAcc && byteOfs == pcfg_pkg::OFS_MEMBASE) begin
            if (laneOn[1]) begin
                memBase_ff[3:0] <= cfgWrData[15:12];
            end
            if (laneOn[2]) begin
                memBase_ff[11:4] <= cfgWrData[23:16];
            end
            if (laneOn[3]) begin
                memBase_ff[19:12] <= cfgWrData[31:24];
            end
        end
    end
    // 4 kB window decode gated by memory enable
    assign memHit = memValid && command_ff[pcfg_pkg::CMD_MEM] && (memAddr[31:12] == memBase_ff);

    // --------------------------------------------------------------
    // subsystem identity
    // --------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            subsysId_ff <= pcfg_pkg::SUBSYS_RESET;
        end else if (wrAcc && byteOfs == pcfg_pkg::OFS_SUBSYS) begin
            if (laneOn[2]) begin
                subsysId_ff[7:0] <= cfgWrData[23:16];
            end
            if (laneOn[3]) begin
                subsysId_ff[15:8] <= cfgWrData[31:24];
            end
        end
    end

    // vendor half only while its write enable is on
    always_ff @(posedge clk) begin
        if (rst) begin
            subsysVendor_ff <= pcfg_pkg::SUBSYS_RESET;
        end else if (wrAcc && byteOfs == pcfg_pkg::OFS_SUBSYS && subsystemVendorWriteEnable) begin
            if (laneOn[0]) begin
                subsysVendor_ff[7:0] <= cfgWrData[7:0];
            end
            if (laneOn[1]) begin
                subsysVendor_ff[15:8] <= cfgWrData[15:8];
            end
        end
    end

    // --------------------------------------------------------------
    // read mux and answer
    // --------------------------------------------------------------
    // unmapped offsets read zero
    always_comb begin
        case (byteOfs)
            pcfg_pkg::OFS_IDENT: nxt_cfgRdData = {PART_CODE, MAKER_CODE};
            pcfg_pkg::OFS_CMDSTS: nxt_cfgRdData = statusWord;
            pcfg_pkg::OFS_REVCLASS: nxt_cfgRdData = {pcfg_pkg::CLASS_CODE, REVISION_CODE};
            pcfg_pkg::OFS_HDRLAT: nxt_cfgRdData = {8'h00, pcfg_pkg::HEADER_MULTI, latency_ff, 8'h00};
            pcfg_pkg::OFS_MEMBASE: nxt_cfgRdData = {memBase_ff, pcfg_pkg::MEMBASE_LOW};
            pcfg_pkg::OFS_SUBSYS: nxt_cfgRdData = {subsysId_ff, subsysVendor_ff};
            default: nxt_cfgRdData = 32'h00000000;
        endcase
    end

    // answer one cycle after an accepted cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            cfgAck_ff <= 1'b0;
            cfgRdData_ff <= 32'h00000000;
        end else begin
            cfgAck_ff <= accept;
            if (accept && !cfgWrite) begin
                cfgRdData_ff <= nxt_cfgRdData;
            end
        end
    end
    assign cfgAck = cfgAck_ff;
    assign cfgRdData = cfgRdData_ff;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    ack_decode_a: assert property (@(posedge clk) disable iff (rst)
        cfgAck |-> $past(cfgValid) && $past(cfgIdsel) && $past(cfgAddr[1:0]) == 2'h0)
        else $error("answer without valid decode");
    func_zero_a: assert property (@(posedge clk) disable iff (rst)
        cfgValid && cfgAddr[10:8] != 3'h0 |=> !cfgAck)
        else $error("other function answered");
    ident_read_a: assert property (@(posedge clk) disable iff (rst)
        accept && !cfgWrite && byteOfs == 8'h00 |=> cfgRdData == {PART_CODE, MAKER_CODE})
        else $error("identity readback wrong");
    fixed_status_a: assert property (@(posedge clk) disable iff (rst)
        statusWord[23] && statusWord[20] && statusWord[26:25] == 2'h1)
        else $error("fixed status bits wrong");
    cmd_unused_a: assert property (@(posedge clk) disable iff (rst)
        (commandRead & 16'hfeb9) == 16'h0000)
        else $error("unused command bit set");
    parity_sticky_a: assert property (@(posedge clk) disable iff (rst)
        parityErrSeen ##1 !(wrAcc && byteOfs == 8'h04 && laneOn[3] && cfgWrData[31]) |-> statusWord[31] [*2])
        else $error("parity flag not held");
    serr_gate_a: assert property (@(posedge clk) disable iff (rst)
        !serrOutEnN |-> $past(command_ff[8]) ##1 statusWord[30])
        else $error("system error drive or flag wrong");
    dpr_gate_a: assert property (@(posedge clk) disable iff (rst)
        $rose(sticky_ff[5]) |-> $past(command_ff[6]))
        else $error("parity report without enable");
    master_gate_a: assert property (@(posedge clk) disable iff (rst)
        masterStart |-> busMasterEn)
        else $error("master start while disabled");
    mem_gate_a: assert property (@(posedge clk) disable iff (rst)
        memHit |-> command_ff[1] && memAddr[31:12] == memBase_ff)
        else $error("memory hit while disabled");
    bar_low_a: assert property (@(posedge clk) disable iff (rst)
        accept && !cfgWrite && byteOfs == 8'h10 |=> cfgRdData[11:0] == 12'h008)
        else $error("memory base low bits wrong");
    clear_write_a: assert property (@(posedge clk) disable iff (rst)
        wrAcc && byteOfs == 8'h04 && laneOn[3] && cfgWrData[29] && !masterAbortSeen |=> !sticky_ff[2])
        else $error("status clear failed");
endmodule
`default_nettype wire

// ===== rtl/pcfg_pkg.sv
package pcfg_pkg;
    // --------------------------------------------------------------
    // register byte offsets
    // --------------------------------------------------------------
    localparam logic [7:0] OFS_IDENT = 8'h00;
    localparam logic [7:0] OFS_CMDSTS = 8'h04;
    localparam logic [7:0] OFS_REVCLASS = 8'h08;
    localparam logic [7:0] OFS_HDRLAT = 8'h0c;
    localparam logic [7:0] OFS_MEMBASE = 8'h10;
    localparam logic [7:0] OFS_SUBSYS = 8'h2c;
    // --------------------------------------------------------------
    // decode values
    // --------------------------------------------------------------
    localparam logic [2:0] FUNC_ZERO = 3'h0;
    localparam logic [1:0] CFG_TYPE0 = 2'h0;
    // --------------------------------------------------------------
    // command bit positions
    // --------------------------------------------------------------
    localparam int CMD_MEM = 1;
    localparam int CMD_MASTER = 2;
    localparam int CMD_PARITY = 6;
    localparam int CMD_SERR = 8;
    // --------------------------------------------------------------
    // status bit positions, sticky order: dpe, sse, rma, rta, sta, dpr
    // --------------------------------------------------------------
    localparam int STS_NUM = 6;
    localparam int STS_POS [0:5] = '{31, 30, 29, 28, 27, 24};
    localparam int STS_FB2B = 23;
    localparam int STS_CAPLIST = 20;
    localparam logic [1:0] STS_DEVSEL_MEDIUM = 2'h1;
    // --------------------------------------------------------------
    // fixed contents and reset values
    // --------------------------------------------------------------
    localparam logic [23:0] CLASS_CODE = 24'h040000;
    localparam logic [7:0] HEADER_MULTI = 8'h80;
    localparam logic [11:0] MEMBASE_LOW = 12'h008;
    localparam logic [7:0] LAT_RESET = 8'h00;
    localparam logic [15:0] SUBSYS_RESET = 16'h0000;
    localparam logic [15:0] CMD_RESET = 16'h0000;
endpackage

// ===== test/pcfg_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// host bridge issuing configuration cycles
// ----------------------------------------
module pcfg_host_model (
    input wire logic clk,
    output var logic cfgValid,
    output var logic cfgIdsel,
    output var logic [10:0] cfgAddr,
    output var logic cfgWrite,
    output var logic [3:0] cfgByteEnN,
    output var logic [31:0] cfgWrData,
    input wire logic cfgAck,
    input wire logic [31:0] cfgRdData
);
    // idle bus from time zero
    initial begin
        cfgValid = 1'b0;
        cfgIdsel = 1'b0;
        cfgAddr = 11'h7ff;
        cfgWrite = 1'b0;
        cfgByteEnN = 4'hf;
        cfgWrData = 32'h0;
    end
    // one data phase, released lines show the inverse
    task automatic cyc(input logic w, input logic s, input logic [10:0] a, input logic [3:0] b,
            input logic [31:0] d, output logic k, output logic [31:0] q);
        @(posedge clk);
        cfgValid <= 1'b1;
        cfgIdsel <= s;
        cfgAddr <= a;
        cfgWrite <= w;
        cfgByteEnN <= b;
        cfgWrData <= d;
        @(posedge clk);
        cfgValid <= 1'b0;
        cfgIdsel <= ~s;
        cfgAddr <= ~a;
        cfgWrite <= ~w;
        cfgByteEnN <= ~b;
        cfgWrData <= ~d;
        @(posedge clk);
        k = cfgAck;
        q = cfgRdData;
    endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    // ----------------------------------------
    // bench signals and instances
    // ----------------------------------------
    localparam logic [2:0] F0 = pcfg_pkg::FUNC_ZERO;
    localparam logic [31:0] IDENT = 32'h24681357;
    logic clk, rst, cfgValid, cfgIdsel, cfgWrite, cfgAck, ack, subsystemVendorWriteEnable;
    logic parityErrSeen, addrParityErrTarget, serrRequest, masterAbortSeen, targetAbortReceived;
    logic masterPerrRead, masterPerrWriteSeen, serrOut, serrOutEnN, targetAbortReq, parityReportEn;
    logic busMasterEn, masterStartReq, masterStart, masterActive, grantActive, masterStop;
    logic memValid, memHit;
    logic [10:0] cfgAddr;
    logic [3:0] cfgByteEnN;
    logic [31:0] cfgWrData, cfgRdData, rd, memAddr;
    int failures, checks_done;
    pcfg_config_header #(.PART_CODE(16'h2468), .MAKER_CODE(16'h1357), .REVISION_CODE(8'h05)) u_dut (
        .clk, .rst, .cfgValid, .cfgIdsel, .cfgAddr, .cfgWrite, .cfgByteEnN, .cfgWrData, .cfgAck,
        .cfgRdData, .subsystemVendorWriteEnable, .parityErrSeen, .addrParityErrTarget, .serrRequest,
        .masterAbortSeen, .targetAbortReceived, .masterPerrRead, .masterPerrWriteSeen, .serrOut,
        .serrOutEnN, .targetAbortReq, .parityReportEn, .busMasterEn, .masterStartReq, .masterStart,
        .masterActive, .grantActive, .masterStop, .memValid, .memAddr, .memHit);
    pcfg_host_model u_host (.clk, .cfgValid, .cfgIdsel, .cfgAddr, .cfgWrite, .cfgByteEnN,
        .cfgWrData, .cfgAck, .cfgRdData);
    // compare helpers
    task automatic chk32(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk32({31'h0, g}, {31'h0, e});
    endtask
    // accepted write and checked read
    task automatic wr(input logic [7:0] o, input logic [31:0] d, input logic [3:0] b);
        u_host.cyc(1'b1, 1'b1, {F0, o}, b, d, ack, rd);
        chk1(ack, 1'b1);
    endtask
    task automatic rdc(input logic [7:0] o, input logic [31:0] e);
        u_host.cyc(1'b0, 1'b1, {F0, o}, 4'h0, 32'h0, ack, rd);
        chk1(ack, 1'b1);
        chk32(rd, e);
    endtask
    // one event pulse, then error line and abort request
    task automatic ev(input int i, input logic [1:0] e);
        @(posedge clk);
        case (i)
            0: parityErrSeen <= 1'b1;
            1: serrRequest <= 1'b1;
            2: masterAbortSeen <= 1'b1;
            3: targetAbortReceived <= 1'b1;
            4: addrParityErrTarget <= 1'b1;
            5: masterPerrRead <= 1'b1;
            default: masterPerrWriteSeen <= 1'b1;
        endcase
        @(posedge clk);
        {parityErrSeen, serrRequest, masterAbortSeen, targetAbortReceived} <= 4'h0;
        {addrParityErrTarget, masterPerrRead, masterPerrWriteSeen} <= 3'h0;
        #1 chk32({30'h0, targetAbortReq, serrOutEnN}, {30'h0, e});
    endtask
    // memory probe plus master start request
    task automatic probe(input logic [31:0] a, input logic [1:0] e);
        @(posedge clk);
        memValid <= 1'b1;
        memAddr <= a;
        masterStartReq <= 1'b1;
        #1 chk32({30'h0, memHit, masterStart}, {30'h0, e});
        @(posedge clk);
        memValid <= 1'b0;
        memAddr <= ~a;
        masterStartReq <= 1'b0;
    endtask
    task automatic t_reset();
        logic [7:0] ofs [0:6];
        logic [31:0] exv [0:6];
        ofs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h2c, 8'h14};
        exv = '{IDENT, 32'h02900000, 32'h04000005, 32'h00800000, 32'h00000008, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) rdc(ofs[i], exv[i]);
        chk32({27'h0, serrOutEnN, busMasterEn, parityReportEn, targetAbortReq, serrOut}, 32'h10);
    endtask
    task automatic t_refuse();
        u_host.cyc(1'b1, 1'b0, {F0, 8'h2c}, 4'h0, 32'hffffffff, ack, rd);
        chk1(ack, 1'b0);
        u_host.cyc(1'b1, 1'b1, {F0, 8'h2d}, 4'h0, 32'hffffffff, ack, rd);
        chk1(ack, 1'b0);
        u_host.cyc(1'b1, 1'b1, {3'h1, 8'h2c}, 4'h0, 32'hffffffff, ack, rd);
        chk1(ack, 1'b0);
        wr(8'h00, 32'h0, 4'h0);
        wr(8'h14, 32'hffffffff, 4'h0);
        rdc(8'h00, IDENT);
        rdc(8'h14, 32'h0);
        rdc(8'h2c, 32'h0);
    endtask
    task automatic t_subsys();
        wr(8'h2c, 32'h5a5aa5a5, 4'h0);
        rdc(8'h2c, 32'h5a5a0000);
        @(posedge clk) subsystemVendorWriteEnable <= 1'b1;
        wr(8'h2c, 32'h3c3cc3c3, 4'h8);
        rdc(8'h2c, 32'h5a3cc3c3);
    endtask
    task automatic t_cmd();
        wr(8'h04, 32'h0000ffff, 4'hc);
        rdc(8'h04, 32'h02900146);
        chk32({30'h0, busMasterEn, parityReportEn}, 32'h3);
        wr(8'h10, 32'hffffffff, 4'h0);
        rdc(8'h10, 32'hfffff008);
        probe(32'hfffff7fc, 2'h3);
        probe(32'hffffe000, 2'h1);
        wr(8'h04, 32'h0, 4'hc);
        probe(32'hfffff000, 2'h0);
        chk32({30'h0, busMasterEn, parityReportEn}, 32'h0);
    endtask
    task automatic t_status();
        logic [7:0] sb [0:6];
        sb = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h88, 8'h01, 8'h01};
        ev(1, 2'h1);
        ev(5, 2'h1);
        ev(6, 2'h1);
        rdc(8'h04, 32'h02900000);
        wr(8'h04, 32'h00000144, 4'hc);
        for (int i = 0; i < 7; i++) begin
            ev(i, {i == 4, i != 1});
            rdc(8'h04, {sb[i] | 8'h02, 24'h900144});
            wr(8'h04, 32'h0, 4'h7);
            rdc(8'h04, {sb[i] | 8'h02, 24'h900144});
            wr(8'h04, 32'hff000000, 4'h7);
            rdc(8'h04, 32'h02900144);
        end
    endtask
    task automatic t_latency();
        int n;
        wr(8'h0c, 32'hffff03ff, 4'hd);
        rdc(8'h0c, 32'h00800300);
        @(posedge clk) masterStartReq <= 1'b1;
        @(posedge clk);
        masterStartReq <= 1'b0;
        masterActive <= 1'b1;
        n = 0;
        #1 chk1(masterStop, 1'b0);
        while (masterStop !== 1'b1 && n < 20) begin
            @(posedge clk);
            #1 n++;
        end
        chk32(n, 32'h3);
        @(posedge clk) grantActive <= 1'b1;
        #1 chk1(masterStop, 1'b0);
        @(posedge clk);
        masterActive <= 1'b0;
        grantActive <= 1'b0;
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #200000;
        failures++;
        final_report();
    end
    // main sequence, with a second reset and reset check at the end
    initial begin
        {rst, subsystemVendorWriteEnable, parityErrSeen, addrParityErrTarget, serrRequest} = 5'h10;
        {masterAbortSeen, targetAbortReceived, masterPerrRead, masterPerrWriteSeen} = 4'h0;
        {masterStartReq, masterActive, grantActive, memValid} = 4'h0;
        memAddr = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_refuse();
        t_subsys();
        t_cmd();
        t_status();
        t_latency();
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        final_report();
    end
endmodule
`default_nettype wire
